// ===== rtl/qig_top.sv
`timescale 1ns/1ps
`include "qig_map.svh"
module qig_top
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [5:0] bus_addr,
   input  wire logic       bus_rd,
   input  wire logic       bus_wr,
   input  wire logic [7:0] bus_wdata,
   output logic      [7:0] bus_rdata,
   input  wire logic       interrupt_acknowledge_n,
   output logic            interrupt_request_n,
   output logic      [7:0] ack_vector,
   input  wire logic [7:0] vector_base,
   input  wire logic       bid_valid,
   input  wire logic [5:0] bid_level,
   input  wire logic [1:0] bid_chan,
   input  wire logic [2:0] bid_type,
   input  wire logic [2:0] rx_count [4],
   input  wire logic [2:0] tx_space [4],
   input  wire logic [7:0] rx_data  [4],
   output logic      [3:0] rx_pop,
   output logic      [3:0] tx_push,
   output logic      [7:0] tx_data
);
   qig_cur_if cur_bus ();
   qig_pkg::qig_bus_t state_q;
   logic              ack_q;
   logic [7:0]        ctrl_q;
   logic [2:0]        live_cnt;
   logic              src_rx;
   logic              src_tx;
   logic              ack_edge;
   logic              access;
   qig_pkg::qig_cur_t cur;

   qig_cur_reg u_cur
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .cur_port (cur_bus.owner)
   );

   assign cur = cur_bus.cur;

   ////////////////////////////////////////////////////////////////////////
   // Capture path.

   // Count of the bidding channel: receive data types report readable
   // bytes, transmit types report free space.
   always_comb
   begin
      if (bid_type[1:0] == `QIG_TYPE_TX)
         live_cnt = tx_space[bid_chan];
      else if (bid_type[1:0] == `QIG_TYPE_RX)
         live_cnt = rx_count[bid_chan];
      else
         live_cnt = `QIG_ZERO3;
   end

   // Acknowledge is taken on its falling edge only.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ack_q <= 1'b1;
      else
         ack_q <= interrupt_acknowledge_n;
   end

   assign ack_edge = ack_q && !interrupt_acknowledge_n;

   // Request assertion is not a load source: the service routine may start
   // long after the request, and the winner may have changed by then.
   assign cur_bus.load = ack_edge
                       || (bus_wr && state_q == qig_pkg::QIG_IDLE
                           && bus_addr == `QIG_ADDR_BCNT);
   // Bid type and channel already carry the documented codes, including
   // timer pairs as channel 01 and 11.
   assign cur_bus.win.bytes = bid_valid ? live_cnt : `QIG_ZERO3;
   assign cur_bus.win.src   = bid_valid ? bid_type : `QIG_TYPE_NONE;
   assign cur_bus.win.chan  = bid_valid ? bid_chan : 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Request comparator.

   // Interrupt when the winning bid exceeds the threshold.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         interrupt_request_n <= 1'b1;
      else
         interrupt_request_n <= !(bid_valid && bid_level > ctrl_q[7:2]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Register interface.

   assign src_rx = cur.src[1:0] == `QIG_TYPE_RX;
   assign src_tx = cur.src[1:0] == `QIG_TYPE_TX;
   assign access = (bus_rd || bus_wr) && state_q == qig_pkg::QIG_IDLE;

   // One action per strobe; the strobe must drop before the next access.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         state_q <= qig_pkg::QIG_IDLE;
      else if (access)
         state_q <= bus_rd ? qig_pkg::QIG_READ : qig_pkg::QIG_WRITE;
      else if (!bus_rd && !bus_wr)
         state_q <= qig_pkg::QIG_IDLE;
      else
         state_q <= state_q;
   end

   // Threshold and vector format; both reset to zero.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ctrl_q <= `QIG_CTRL_RESET;
      else if (access && bus_wr && bus_addr == `QIG_ADDR_CTRL)
         ctrl_q <= bus_wdata;
   end

   // Read data register.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         bus_rdata <= 8'h00;
      else if (access && bus_rd)
      begin
         case (bus_addr)
            `QIG_ADDR_CUR:  bus_rdata <= cur;
            `QIG_ADDR_CHAN: bus_rdata <= {`QIG_ZERO6, cur.chan};
            `QIG_ADDR_BCNT: bus_rdata <= {`QIG_ZERO5, src_tx ? tx_space[cur.chan]
                                          : rx_count[cur.chan]};
            `QIG_ADDR_FIFO: bus_rdata <= src_rx ? rx_data[cur.chan]
                                         : `QIG_ALL_ONES;
            `QIG_ADDR_CTRL: bus_rdata <= ctrl_q;
            default:        bus_rdata <= 8'h00;
         endcase
      end
   end

   // Pop and push strobes, one cycle, only toward the current source.
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_ch
         always_ff @(posedge ref_clk)
         begin
            if (rst)
            begin
               rx_pop[g]  <= 1'b0;
               tx_push[g] <= 1'b0;
            end
            else
            begin
               rx_pop[g]  <= access && bus_rd && bus_addr == `QIG_ADDR_FIFO
                             && src_rx && cur.chan == g;
               tx_push[g] <= access && bus_wr && bus_addr == `QIG_ADDR_FIFO
                             && src_tx && cur.chan == g;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         tx_data <= 8'h00;
      else if (access && bus_wr && bus_addr == `QIG_ADDR_FIFO)
         tx_data <= bus_wdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Acknowledge vector, formed from the freshly captured snapshot.

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ack_vector <= `QIG_ALL_ONES;
      else
      begin
         case (ctrl_q[1:0])
            `QIG_VF_FULL: ack_vector <= vector_base;
            `QIG_VF_CHAN: ack_vector <= {vector_base[7:2], cur.chan};
            `QIG_VF_TYPE: ack_vector <= {vector_base[7:5], cur.src, cur.chan};
            `QIG_VF_NONE: ack_vector <= `QIG_ALL_ONES;
            default:      ack_vector <= `QIG_ALL_ONES;
         endcase
      end
   end
endmodule

// ===== rtl/qig_map.svh
// Overview of operation
// - Capture only on acknowledge or update command.
// - Current interrupt holds count, type, channel.
// - Source type codes for each interrupt cause.
// - Count is bytes readable or writable.
// - Byte-count read gives live counter, zero-padded.
// - Acknowledge captures count valid at that moment.
// - Receive read without receiver source gives ones.
// - Transmit write without transmitter source ignored.
// - Channel read gives captured channel, zero-padded.
// - Timer pairs report channel 01 and 11.
// - Winning bid compared against reset-zero threshold.
// - Vector control selects acknowledge vector kind.
// - Four vector formats; field resets to 00.
// - Interrupt control readable and writable at 2C.
`ifndef QIG_MAP_SVH
`define QIG_MAP_SVH
`define QIG_ADDR_CUR      6'h28
`define QIG_ADDR_CHAN     6'h29
`define QIG_ADDR_BCNT     6'h2A
`define QIG_ADDR_FIFO     6'h2B
`define QIG_ADDR_CTRL     6'h2C
`define QIG_TYPE_NONE     3'h0
`define QIG_TYPE_COS      3'h1
`define QIG_TYPE_TX       2'h2
`define QIG_TYPE_RXOK     3'h3
`define QIG_TYPE_RX       2'h3
`define QIG_ZERO3         3'h0
`define QIG_TYPE_BRK      3'h4
`define QIG_TYPE_CT       3'h5
`define QIG_TYPE_RXERR    3'h7
`define QIG_CHAN_CT_AB    2'h1
`define QIG_CHAN_CT_CD    2'h3
`define QIG_VF_FULL       2'h0
`define QIG_VF_CHAN       2'h1
`define QIG_VF_TYPE       2'h2
`define QIG_VF_NONE       2'h3
`define QIG_CTRL_RESET    8'h00
`define QIG_ALL_ONES      8'hFF
`define QIG_ZERO5         5'h00
`define QIG_ZERO6         6'h00
`endif

// ===== rtl/qig_pkg.sv
package qig_pkg;
   typedef logic [1:0] qig_chan_t;
   typedef logic [2:0] qig_type_t;
   typedef logic [2:0] qig_count_t;
   typedef struct packed
   {
      qig_count_t bytes;
      qig_type_t  src;
      qig_chan_t  chan;
   } qig_cur_t;
   // Bus access states: idle, read in progress, write in progress.
   typedef enum logic [1:0]
   {
      QIG_IDLE  = 2'b00,
      QIG_READ  = 2'b01,
      QIG_WRITE = 2'b11
   } qig_bus_t;
endpackage

// ===== rtl/qig_cur_if.sv
`timescale 1ns/1ps
interface qig_cur_if;
   logic             load;
   qig_pkg::qig_cur_t win;
   qig_pkg::qig_cur_t cur;
   modport owner (input load, input win, output cur);
   modport user  (output load, output win, input cur);
endinterface

// ===== rtl/qig_cur_reg.sv
`timescale 1ns/1ps
`include "qig_map.svh"
module qig_cur_reg
(
   input  wire logic ref_clk,
   input  wire logic rst,
   qig_cur_if.owner  cur_port
);
   qig_pkg::qig_cur_t cur_q;

   // Snapshot of the winner; holds between acknowledges and update commands
   // so a slow service routine still sees the interrupt it was called for.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cur_q <= '0;
      end
      else if (cur_port.load)
      begin
         cur_q <= cur_port.win;
      end
   end

   assign cur_port.cur = cur_q;
endmodule

// ===== dv/qig_glob_monitor.sv
`timescale 1ns/1ps
// Port-level checker for the global pseudo-register block.
module qig_glob_monitor
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [5:0] bus_addr,
   input wire logic       bus_rd,
   input wire logic       bus_wr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic       bid_valid,
   input wire logic       interrupt_request_n,
   input wire logic [3:0] rx_pop,
   input wire logic [3:0] tx_push,
   input wire logic [7:0] tx_data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Strobes are taken on their first cycle only, so $rose marks a taken read.
   property p_irq_off; !bid_valid |=> interrupt_request_n; endproperty
   a_irq_off: assert property (p_irq_off) else $error("Request without bid");
   property p_pop_cause; |rx_pop |-> $past(bus_rd) && $past(bus_addr) == 6'h2B; endproperty
   a_pop_cause: assert property (p_pop_cause) else $error("Stray pop");
   property p_pop_pulse; |rx_pop |=> rx_pop == 4'h0; endproperty
   a_pop_pulse: assert property (p_pop_pulse) else $error("Pop too long");
   property p_push_cause; |tx_push |-> $past(bus_wr) && $past(bus_addr) == 6'h2B; endproperty
   a_push_cause: assert property (p_push_cause) else $error("Stray push");
   property p_push_data; |tx_push |-> tx_data == $past(bus_wdata); endproperty
   a_push_data: assert property (p_push_data) else $error("Push data wrong");
   property p_bcnt_pad; $rose(bus_rd) && bus_addr == 6'h2A |=> bus_rdata[7:3] == 5'h00; endproperty
   a_bcnt_pad: assert property (p_bcnt_pad) else $error("Count not padded");
   property p_chan_pad; $rose(bus_rd) && bus_addr == 6'h29 |=> bus_rdata[7:2] == 6'h00; endproperty
   a_chan_pad: assert property (p_chan_pad) else $error("Channel not padded");
   property p_fifo_ones; $rose(bus_rd) && bus_addr == 6'h2B |=> (|rx_pop) || bus_rdata == 8'hFF; endproperty
   a_fifo_ones: assert property (p_fifo_ones) else $error("Empty fifo read");
endmodule

// ===== dv/qig_far_model.sv
`timescale 1ns/1ps
// Far-side channels: a pop takes one byte, a push uses one space.
module qig_far_model
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [3:0] rx_pop,
   input  wire logic [3:0] tx_push,
   output logic      [2:0] rx_count [4],
   output logic      [2:0] tx_space [4],
   output logic      [7:0] rx_data  [4]
);
   // Counts differ per channel so that a wrong channel shows at once.
   always_ff @(posedge ref_clk)
   begin
      for (int c = 0; c < 4; c++)
      begin
         rx_count[c] <= rst ? 3'(c + 3) : rx_count[c] - {2'h0, rx_pop[c]};
         tx_space[c] <= rst ? 3'(7 - c) : tx_space[c] - {2'h0, tx_push[c]};
      end
   end
   // Byte carries the channel and the fill level.
   always_comb
   begin
      for (int c = 0; c < 4; c++)
         rx_data[c] = {2'(c), 3'h0, rx_count[c]};
   end
endmodule

// ===== dv/qig_top_bench.sv
`timescale 1ns/1ps
module qig_top_bench;
   logic       ref_clk = 1'b0, rst = 1'b1, bus_rd = 1'b0, bus_wr = 1'b0;
   logic [5:0] bus_addr = 6'h00, bid_level = 6'h00;
   logic [7:0] bus_wdata = 8'h00, vector_base = 8'hA5, bus_rdata, ack_vector, tx_data;
   logic       interrupt_acknowledge_n = 1'b1, bid_valid = 1'b0, interrupt_request_n;
   logic [1:0] bid_chan = 2'h0;
   logic [2:0] bid_type = 3'h0;
   logic [2:0] rx_count [4], tx_space [4];
   logic [7:0] rx_data  [4];
   logic [3:0] rx_pop, tx_push;
   int         n_mismatch = 0, samples_checked = 0;
   always #20 ref_clk = ~ref_clk;
   qig_top qig_top_i (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
      .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .interrupt_acknowledge_n(interrupt_acknowledge_n), .interrupt_request_n(interrupt_request_n),
      .ack_vector(ack_vector), .vector_base(vector_base), .bid_valid(bid_valid),
      .bid_level(bid_level), .bid_chan(bid_chan), .bid_type(bid_type), .rx_count(rx_count),
      .tx_space(tx_space), .rx_data(rx_data), .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data));
   qig_far_model qig_far_model_i (.ref_clk(ref_clk), .rst(rst), .rx_pop(rx_pop),
      .tx_push(tx_push), .rx_count(rx_count), .tx_space(tx_space), .rx_data(rx_data));
   ////////////////////////////////////////////////////////////////////////////////
   // A strobe stands for one cycle and drops before the next, as the bus requires.
   task chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         $display("ERROR %0t got %h want %h", $time, g, e);
         n_mismatch++;
      end
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge ref_clk) {bus_addr, bus_rd} <= {a, 1'b1};
      @(posedge ref_clk) bus_rd <= 1'b0;
      #1 chk(bus_rdata, e);
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge ref_clk) {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
      @(posedge ref_clk) bus_wr <= 1'b0;
      #1;
   endtask
   task ack;
      @(posedge ref_clk) interrupt_acknowledge_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      interrupt_acknowledge_n <= 1'b1;
   endtask
   task stop_test;
      $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence: reset values, threshold, refusals, capture, formats, update command.
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      #1 chk(ack_vector, 8'hFF);
      rd(6'h2C, 8'h00);
      wr(6'h2C, 8'h10);
      rd(6'h2C, 8'h10);
      {bid_valid, bid_level, bid_chan, bid_type} <= {1'b1, 6'h04, 2'h2, 3'h3};
      repeat (3) @(posedge ref_clk);
      #1 chk({7'h00, interrupt_request_n}, 8'h01);
      bid_level <= 6'h05;
      repeat (3) @(posedge ref_clk);
      #1 chk({7'h00, interrupt_request_n}, 8'h00);
      rd(6'h28, 8'h00);
      rd(6'h2B, 8'hFF);
      wr(6'h2B, 8'h33);
      chk({4'h0, tx_push}, 8'h00);
      ack;
      rd(6'h28, 8'hAE);
      rd(6'h29, 8'h02);
      rd(6'h2A, 8'h05);
      rd(6'h2B, 8'h85);
      rd(6'h2A, 8'h04);
      rd(6'h28, 8'hAE);
      chk(ack_vector, 8'hA5);
      for (int f = 1; f < 4; f++)
      begin
         wr(6'h2C, {6'h04, 2'(f)});
         repeat (2) @(posedge ref_clk);
         #1 chk(ack_vector, f == 1 ? 8'hA6 : f == 2 ? 8'hAE : 8'hFF);
      end
      {bid_chan, bid_type} <= {2'h3, 3'h5};
      ack;
      rd(6'h28, 8'h17);
      rd(6'h2B, 8'hFF);
      {bid_chan, bid_type} <= {2'h1, 3'h2};
      wr(6'h2A, 8'h00);
      rd(6'h28, 8'hC9);
      wr(6'h2B, 8'h3C);
      chk({4'h0, tx_push}, 8'h02);
      rd(6'h2A, 8'h05);
      stop_test;
   end
endmodule
bind qig_top qig_glob_monitor qig_glob_monitor_i (.ref_clk(ref_clk), .rst(rst),
   .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata), .bid_valid(bid_valid), .interrupt_request_n(interrupt_request_n),
   .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data));
